// *** src/vtp_pkg.sv ***
// What this block does
// - Select bit zero: vectors at flash start
// - Boot base comes from boot-size fuses
// - Block interrupts from unlock until next instruction after select write
// - No select write: block lasts four cycles
// - Global interrupt enable never altered
// - Unlock clears after four cycles or select
// - Boot vectors, app lock: mute in application
// - App vectors, boot lock: mute in boot
// - Boot fuse set: reset at boot base
// - Fuse clear, relocated: reset stays zero
// - Relocated vectors at two-word spacing above base
// - Boot fuse one unprogrammed, zero programmed
//
// Purpose: constants for the vector table placement control
// Assumes: word addressed program flash, 8-bit control register
// Notes: fuse and lock inputs use zero for programmed
`default_nettype none
package vtp_pkg;
  localparam int ADDR_W = 16;
  localparam int REG_ADDR_W = 8;
  localparam logic [7:0] MCU_CTRL_OFS = 8'h35;
  localparam logic [7:0] MCU_CTRL_RST = 8'h00;
  localparam int DPD_BIT = 7;
  localparam int PUD_BIT = 4;
  localparam int SEL_BIT = 1;
  localparam int UNLK_BIT = 0;
  localparam logic [2:0] UNLOCK_CYC = 3'h4;
  localparam logic [2:0] CNT_LAST = 3'h1;
  localparam logic [ADDR_W-1:0] VEC_OFS = 16'h0002;
  localparam logic [ADDR_W-1:0] VEC_STRIDE = 16'h0002;
  localparam logic [ADDR_W-1:0] RESET_APP = 16'h0000;
  localparam logic [ADDR_W-1:0] BOOT_MIN_WORDS = 16'h0100;
  localparam logic [ADDR_W-1:0] FLASH_WORDS_SMALL = 16'h4000;
  localparam logic FUSE_PROG = 1'b0;
  typedef enum logic [1:0] {
    VTP_IDLE = 2'b00,
    VTP_UNLOCKED = 2'b01,
    VTP_POST_WRITE = 2'b10
  } vtp_state_t;
endpackage
`default_nettype wire

// *** src/vtp_addr_map.sv ***
// Purpose: boot base, interrupt table start and reset address
// Assumes: fuses are static while the core runs
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
module vtp_addr_map
  import vtp_pkg::*;
#(
  parameter logic [ADDR_W-1:0] FLASH_WORDS = FLASH_WORDS_SMALL
)
(
  input wire logic [1:0] boot_size_fuses,
  input wire logic boot_reset_fuse,
  input wire logic vector_table_select,
  output logic [ADDR_W-1:0] boot_base,
  output logic [ADDR_W-1:0] int_start,
  output logic [ADDR_W-1:0] reset_addr
);
  // Smaller fuse code means larger boot section
  wire [1:0] size_shift = ~boot_size_fuses;
  wire [ADDR_W-1:0] boot_words = BOOT_MIN_WORDS << size_shift;
  assign boot_base = FLASH_WORDS - boot_words;
  // Table start moves with the select bit
  assign int_start = (vector_table_select ? boot_base : RESET_APP) + VEC_OFS;
  // Reset target independent of the select bit
  assign reset_addr = (boot_reset_fuse == FUSE_PROG) ? boot_base : RESET_APP;
endmodule // vtp_addr_map
`default_nettype wire

// *** src/vtp_ctrl.sv ***
// Purpose: timed vector table relocation and interrupt gating
// Assumes: core reports execution region and instruction ends
// Notes: lowest numbered pending request wins
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module vtp_ctrl
  import vtp_pkg::*;
#(
  parameter int NUM_IRQ = 23,
  parameter logic [ADDR_W-1:0] FLASH_WORDS = vtp_pkg::FLASH_WORDS_SMALL,
  parameter int IDX_W = $clog2(NUM_IRQ)
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [vtp_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] boot_size_fuses,
  input wire logic boot_reset_fuse,
  input wire logic app_side_boot_lock,
  input wire logic boot_side_lock,
  input wire logic exec_in_boot,
  input wire logic instr_done,
  input wire logic global_irq_enable,
  input wire logic [NUM_IRQ-1:0] irq_req,
  input wire logic [NUM_IRQ-1:0] irq_en,
  output logic irq_take,
  output logic [IDX_W-1:0] irq_id,
  output logic [vtp_pkg::ADDR_W-1:0] irq_vector_addr,
  output logic [vtp_pkg::ADDR_W-1:0] reset_vector_addr,
  output logic irq_blocked,
  output logic vector_table_select,
  output logic vector_change_unlock,
  output logic debug_port_disable,
  output logic pullup_disable
);
  import vtp_pkg::*;

  // Index of the lowest set bit, used for arbitration
  function automatic logic [IDX_W-1:0] first_set(input logic [NUM_IRQ-1:0] v);
    logic [IDX_W-1:0] idx;
    idx = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        idx = IDX_W'(i);
      end
    end
    return idx;
  endfunction

  vtp_state_t state_ff;
  vtp_state_t nxt_state;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic unlk_ff;
  logic sel_ff;
  logic dpd_ff;
  logic pud_ff;
  logic [7:0] rdata_ff;
  logic [NUM_IRQ-1:0] pend_ff;
  logic take_ff;
  logic [IDX_W-1:0] id_ff;
  logic [ADDR_W-1:0] vec_ff;
  logic [ADDR_W-1:0] rst_vec_ff;
  logic blocked_ff;
  logic [ADDR_W-1:0] boot_base;
  logic [ADDR_W-1:0] int_start;
  logic [ADDR_W-1:0] reset_addr;

  // Register bus decode
  wire reg_hit = (reg_addr == MCU_CTRL_OFS);
  wire wr_hit = reg_wr & reg_hit;
  wire rd_hit = reg_rd & reg_hit;
  // Flop copy of the window state, so the unlock output is registered
  wire unlocked = unlk_ff;
  // A write with the unlock bit one arms the change window
  wire wr_unlock = wr_hit & reg_wdata[UNLK_BIT];
  // Select only lands inside the window, with unlock written zero
  wire wr_select = wr_hit & ~reg_wdata[UNLK_BIT] & unlocked;
  wire cnt_done = (cnt_ff == CNT_LAST);
  wire [7:0] reg_view = {dpd_ff, 2'b00, pud_ff, 2'b00, sel_ff, unlocked};

  // Address map from fuses and current select bit
  vtp_addr_map #(
    .FLASH_WORDS(FLASH_WORDS)
  ) i_vtp_addr_map (
    .boot_size_fuses(boot_size_fuses),
    .boot_reset_fuse(boot_reset_fuse),
    .vector_table_select(sel_ff),
    .boot_base(boot_base),
    .int_start(int_start),
    .reset_addr(reset_addr)
  );

  // Unlock window and post-write sequencing
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    unique case (state_ff)
      VTP_IDLE:
      begin
        if (wr_unlock)
        begin
          nxt_state = VTP_UNLOCKED;
          nxt_cnt = UNLOCK_CYC;
        end
      end
      VTP_UNLOCKED:
      begin
        if (wr_select)
        begin
          nxt_state = VTP_POST_WRITE;
        end
        else if (wr_unlock)
        begin
          nxt_cnt = UNLOCK_CYC;
        end
        else if (cnt_done)
        begin
          nxt_state = VTP_IDLE;
        end
        else
        begin
          nxt_cnt = cnt_ff - CNT_LAST;
        end
      end
      VTP_POST_WRITE:
      begin
        // Block held until the next instruction retires
        if (wr_unlock)
        begin
          nxt_state = VTP_UNLOCKED;
          nxt_cnt = UNLOCK_CYC;
        end
        else if (instr_done)
        begin
          nxt_state = VTP_IDLE;
        end
      end
      default:
      begin
        nxt_state = VTP_IDLE;
      end
    endcase
  end

  // Region lock gating, active while fetching from the wrong side
  wire app_mute = sel_ff & (app_side_boot_lock == FUSE_PROG) & ~exec_in_boot;
  wire boot_mute = ~sel_ff & (boot_side_lock == FUSE_PROG) & exec_in_boot;
  // Sequence block is separate from the global enable, never written
  wire seq_block = (state_ff != VTP_IDLE);
  wire blocked_now = seq_block | app_mute | boot_mute;
  wire [NUM_IRQ-1:0] avail = pend_ff & irq_en & {NUM_IRQ{global_irq_enable}};
  wire grant = (|avail) & ~blocked_now;
  wire [IDX_W-1:0] win_idx = first_set(avail);
  wire [ADDR_W-1:0] win_vec = int_start + ADDR_W'(ADDR_W'(win_idx) * VEC_STRIDE);
  wire [NUM_IRQ-1:0] grant_hot = grant ? (NUM_IRQ'(1) << win_idx) : '0;

  // Pending latches: a new request beats the grant clear
  genvar g;
  generate
    for (g = 0; g < NUM_IRQ; g++)
    begin : g_pend
      always_ff @(posedge sys_clk)
      begin
        if (!reset_n)
          pend_ff[g] <= 1'b0;
        else
          pend_ff[g] <= irq_req[g] | (pend_ff[g] & ~grant_hot[g]);
      end
    end
  endgenerate

  // Sequencer state
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state_ff <= VTP_IDLE;
      cnt_ff <= 3'h0;
      unlk_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      unlk_ff <= (nxt_state == VTP_UNLOCKED);
    end
  end

  // Control register bits
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      sel_ff <= MCU_CTRL_RST[SEL_BIT];
      dpd_ff <= MCU_CTRL_RST[DPD_BIT];
      pud_ff <= MCU_CTRL_RST[PUD_BIT];
    end
    else
    begin
      if (wr_select)
        sel_ff <= reg_wdata[SEL_BIT];
      if (wr_hit)
      begin
        dpd_ff <= reg_wdata[DPD_BIT];
        pud_ff <= reg_wdata[PUD_BIT];
      end
    end
  end

  // Read data lives for exactly one cycle
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= rd_hit ? reg_view : 8'h00;
  end

  // Grant outputs; vector address registered with the grant
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      take_ff <= 1'b0;
      id_ff <= '0;
      vec_ff <= '0;
      rst_vec_ff <= RESET_APP;
      blocked_ff <= 1'b0;
    end
    else
    begin
      take_ff <= grant;
      id_ff <= grant ? win_idx : id_ff;
      vec_ff <= grant ? win_vec : vec_ff;
      rst_vec_ff <= reset_addr;
      blocked_ff <= blocked_now;
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq_take = take_ff;
  assign irq_id = id_ff;
  assign irq_vector_addr = vec_ff;
  assign reset_vector_addr = rst_vec_ff;
  assign irq_blocked = blocked_ff;
  assign vector_table_select = sel_ff;
  assign vector_change_unlock = unlocked;
  assign debug_port_disable = dpd_ff;
  assign pullup_disable = pud_ff;

  // Checks on the sequencing and gating
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Unlock armed with no further register writes
  sequence s_arm;
    (state_ff == VTP_IDLE) && wr_unlock;
  endsequence
  sequence s_quiet4;
    (!wr_hit)[*4];
  endsequence

  a_unlock_expiry: assert property (s_arm ##1 s_quiet4 |=> !vector_change_unlock)
    else $error("unlock bit outlived four cycles");
  a_unlock_hold: assert property (s_arm ##1 (!wr_hit)[*3] |-> vector_change_unlock)
    else $error("unlock window ended early");
  a_select_clear: assert property (wr_select |=> !vector_change_unlock && seq_block)
    else $error("select write left unlock set");
  a_select_guard: assert property (!wr_select |=> $stable(vector_table_select))
    else $error("select changed outside window");
  a_select_take: assert property (wr_select |=> vector_table_select == $past(reg_wdata[SEL_BIT]))
    else $error("select value not taken");
  a_block_grant: assert property (seq_block |=> !irq_take)
    else $error("interrupt granted inside unlock sequence");
  a_post_release: assert property ((state_ff == VTP_POST_WRITE) && instr_done && !wr_unlock |=> !seq_block)
    else $error("block not released after instruction");
  a_app_mute: assert property (app_mute |=> !irq_take)
    else $error("interrupt in application with boot lock");
  a_boot_mute: assert property (boot_mute |=> !irq_take)
    else $error("interrupt in boot with boot-side lock");
  a_pend_kept: assert property (blocked_now |=> ($past(pend_ff) & ~pend_ff) == '0)
    else $error("pending request dropped while blocked");
  a_vec_space: assert property (grant |=> irq_vector_addr == int_start + 16'(16'(irq_id) * VEC_STRIDE))
    else $error("vector address off stride");
  a_reset_base: assert property (boot_reset_fuse == FUSE_PROG ##1 $stable(boot_size_fuses)
                                  |-> reset_vector_addr == boot_base)
    else $error("reset vector not at boot base");
  a_reset_zero: assert property (boot_reset_fuse != FUSE_PROG |=> reset_vector_addr == RESET_APP)
    else $error("reset vector moved while fuse clear");
  a_ie_gate: assert property (!global_irq_enable |=> !irq_take)
    else $error("grant with global enable off");
endmodule // vtp_ctrl
`default_nettype wire

// *** testbench/vtp_ctrl_test.sv ***
// Purpose: self-checking bench for the vector table placement control
// Assumes: default parameters, fuse and lock inputs read zero as programmed
// Notes: the bench plays core and software; requests are single pulses
`timescale 1ns/100ps
`default_nettype none
module vtp_ctrl_test;
  import vtp_pkg::*;
  logic sys_clk, reset_n, reg_wr, reg_rd, boot_reset_fuse, app_side_boot_lock, boot_side_lock;
  logic exec_in_boot, instr_done, global_irq_enable, irq_take, irq_blocked;
  logic vector_table_select, vector_change_unlock, debug_port_disable, pullup_disable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] boot_size_fuses;
  logic [22:0] irq_req, irq_en;
  logic [4:0] irq_id;
  logic [15:0] irq_vector_addr, reset_vector_addr, rd;
  int fails, n_tests;
  // Boot base per size code at the default flash size
  localparam logic [15:0] BASE_TBL [4] = '{16'h3800, 16'h3C00, 16'h3E00, 16'h3F00};

  vtp_ctrl i_vtp_ctrl (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .boot_size_fuses(boot_size_fuses),
    .boot_reset_fuse(boot_reset_fuse), .app_side_boot_lock(app_side_boot_lock),
    .boot_side_lock(boot_side_lock), .exec_in_boot(exec_in_boot), .instr_done(instr_done),
    .global_irq_enable(global_irq_enable), .irq_req(irq_req), .irq_en(irq_en),
    .irq_take(irq_take), .irq_id(irq_id), .irq_vector_addr(irq_vector_addr),
    .reset_vector_addr(reset_vector_addr), .irq_blocked(irq_blocked),
    .vector_table_select(vector_table_select), .vector_change_unlock(vector_change_unlock),
    .debug_port_disable(debug_port_disable), .pullup_disable(pullup_disable)
  );

  // 200 MHz system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // One-cycle write strobe; returns just after the taking edge
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the read edge
  task automatic reg_read(input logic [7:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    v = {8'h00, reg_rdata};
  endtask

  task automatic pulse_irq(input logic [22:0] m);
    @(posedge sys_clk);
    irq_req <= m;
    @(posedge sys_clk);
    irq_req <= '0;
    #1;
  endtask

  task automatic step_done();
    @(posedge sys_clk);
    instr_done <= 1'b1;
    @(posedge sys_clk);
    instr_done <= 1'b0;
    #1;
  endtask

  // Bounded wait for a grant, then check index and vector
  task automatic wait_take(input logic [4:0] id, input logic [15:0] vec);
    int k;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    while (irq_take !== 1'b1 && k < 20);
    chk_bit(irq_take, 1'b1);
    chk_val({11'h000, irq_id}, {11'h000, id});
    chk_val(irq_vector_addr, vec);
  endtask

  task automatic no_take(input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      #1;
      chk_bit(irq_take, 1'b0);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog well beyond the hundred or so cycles the sequence needs
  initial
  begin
    repeat (4000) @(posedge sys_clk);
    fails++;
    final_report();
  end

  initial
  begin
    reset_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    boot_size_fuses = 2'b00; boot_reset_fuse = 1'b1; app_side_boot_lock = 1'b1;
    boot_side_lock = 1'b1; exec_in_boot = 1'b0; instr_done = 1'b0;
    global_irq_enable = 1'b1; irq_req = '0; irq_en = '1; fails = 0; n_tests = 0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    // Reset contents, unmapped place, plain writes
    reg_read(MCU_CTRL_OFS, rd);
    chk_val(rd, 16'h0000);
    chk_val(reset_vector_addr, 16'h0000);
    reg_write(8'h34, 8'hFF);
    reg_read(8'h34, rd);
    chk_val(rd, 16'h0000);
    reg_write(MCU_CTRL_OFS, 8'hFE);
    reg_read(MCU_CTRL_OFS, rd);
    chk_val(rd, 16'h0090);
    chk_bit(debug_port_disable, 1'b1);
    chk_bit(pullup_disable, 1'b1);
    reg_write(MCU_CTRL_OFS, 8'h00);
    chk_bit(debug_port_disable, 1'b0);
    chk_bit(pullup_disable, 1'b0);
    // Unlock left to expire
    reg_write(MCU_CTRL_OFS, 8'h01);
    chk_bit(vector_change_unlock, 1'b1);
    @(posedge sys_clk);
    #1;
    chk_bit(irq_blocked, 1'b1);
    repeat (2) @(posedge sys_clk);
    #1;
    chk_bit(vector_change_unlock, 1'b1);
    @(posedge sys_clk);
    #1;
    chk_bit(vector_change_unlock, 1'b0);
    repeat (3) @(posedge sys_clk);
    #1;
    chk_bit(irq_blocked, 1'b0);
    chk_bit(vector_table_select, 1'b0);
    // Relocate, request held pending across the block
    reg_write(MCU_CTRL_OFS, 8'h01);
    reg_write(MCU_CTRL_OFS, 8'h02);
    chk_bit(vector_table_select, 1'b1);
    chk_bit(vector_change_unlock, 1'b0);
    pulse_irq(23'h000008);
    no_take(6);
    chk_bit(irq_blocked, 1'b1);
    step_done();
    wait_take(5'd3, 16'h3808);
    @(posedge sys_clk);
    global_irq_enable <= 1'b0;
    pulse_irq(23'h200000);
    no_take(4);
    @(posedge sys_clk);
    global_irq_enable <= 1'b1;
    wait_take(5'd21, 16'h382C);
    pulse_irq(23'h000210);
    wait_take(5'd4, 16'h380A);
    wait_take(5'd9, 16'h3814);
    // Boot vectors with the application lock programmed
    @(posedge sys_clk);
    app_side_boot_lock <= 1'b0;
    pulse_irq(23'h000020);
    no_take(5);
    @(posedge sys_clk);
    exec_in_boot <= 1'b1;
    wait_take(5'd5, 16'h380C);
    @(posedge sys_clk);
    app_side_boot_lock <= 1'b1;
    // Back to application vectors, boot lock programmed
    reg_write(MCU_CTRL_OFS, 8'h01);
    reg_write(MCU_CTRL_OFS, 8'h00);
    chk_bit(vector_table_select, 1'b0);
    step_done();
    @(posedge sys_clk);
    boot_side_lock <= 1'b0;
    pulse_irq(23'h000080);
    no_take(5);
    @(posedge sys_clk);
    exec_in_boot <= 1'b0;
    wait_take(5'd7, 16'h0010);
    // Boot reset fuse programmed, table still at flash start
    @(posedge sys_clk);
    boot_side_lock <= 1'b1;
    boot_reset_fuse <= 1'b0;
    pulse_irq(23'h000001);
    wait_take(5'd0, 16'h0002);
    chk_val(reset_vector_addr, 16'h3800);
    // Reset address for every boot size with fuse programmed, then fuse clear at size code 3
    for (int s = 0; s < 4; s++)
    begin
      @(posedge sys_clk);
      boot_size_fuses <= 2'(s);
      boot_reset_fuse <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      chk_val(reset_vector_addr, BASE_TBL[s]);
    end
    @(posedge sys_clk);
    boot_reset_fuse <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk_val(reset_vector_addr, 16'h0000);
    final_report();
  end
endmodule // vtp_ctrl_test
`default_nettype wire
